/* sfe_pkg.sv */
package sfe_pkg;
   localparam int CLK_NS = 8;

   // instruction codes seen on the link
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
   localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
   localparam logic [7:0] OP_ARRAY_WIPE = 8'hc7;
   localparam logic [7:0] OP_HALT_MODIFY = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_PROGRAM = 8'h02;

   // byte counts of complete frames
   localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
   localparam logic [2:0] LEN_WITH_ADDR = 3'h4;
   localparam logic [2:0] LEN_MIN_PROGRAM = 3'h5;

   // address layout
   localparam int ADDR_W = 24;
   localparam int SECT_LSB = 16;
   localparam int SECT_W = 8;
   localparam logic [23:0] SUB_MASK = 24'hff_f000;
   localparam logic [23:0] SECT_MASK = 24'hff_0000;
   localparam logic [7:0] BOOT_SECTORS = 8'h08;
   localparam logic [8:0] NUM_SECTORS = 9'h100;

   // architecture variants
   localparam int ARCH_UNIFORM = 0;
   localparam int ARCH_BOOT_BOTTOM = 1;
   localparam int ARCH_BOOT_TOP = 2;

   // flag status byte
   localparam int FS_READY_BIT = 7;
   localparam int FS_SUSP_BIT = 2;

   // suspend latencies, least times rounded up
   localparam int SUSP_LAT_PROG_NS = 7000;
   localparam int SUSP_LAT_WIPE_NS = 15000;
   localparam int SUSP_LAT_PROG_CYC = (SUSP_LAT_PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int SUSP_LAT_WIPE_CYC = (SUSP_LAT_WIPE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LAT_W = 11;

   // host-side guard before a suspend
   localparam int WIPE_TO_SUSP_NS = 40000;
   localparam int PROG_TO_SUSP_NS = 5000;
   localparam int WIPE_TO_SUSP_CYC = (WIPE_TO_SUSP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_TO_SUSP_CYC = (PROG_TO_SUSP_NS + CLK_NS - 1) / CLK_NS;
   localparam int GUARD_W = 16;

   localparam int TIMER_W = 24;
   localparam int LINK_HALF_CYC = 4;

   typedef enum logic [1:0] {
      CYC_IDLE = 2'b00,
      CYC_RUN = 2'b01,
      CYC_LAT = 2'b11
   } sfe_cyc_t;

   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_SMALL = 3'b001,
      K_BLOCK = 3'b011,
      K_ARRAY = 3'b010,
      K_PROG = 3'b110
   } sfe_kind_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW = 3'b001,
      H_HIGH = 3'b011,
      H_END = 3'b010,
      H_GAP = 3'b110
   } sfe_hst_t;
endpackage

/* sfe_link_if.sv */
`timescale 1ns/1ns
interface sfe_link_if;
   logic csN;
   logic sclk;
   logic serialIn;

   modport host (
      output csN,
      output sclk,
      output serialIn
   );

   modport dev (
      input csN,
      input sclk,
      input serialIn
   );
endinterface

/* sfe_sync.sv */
`timescale 1ns/1ns
module sfe_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sfe_sync_st_t;

   sfe_sync_st_t s_q;
   sfe_sync_st_t s_d;

   always_comb begin
      s_d.meta = din;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stable;
endmodule

/* sfe_dev.sv */
`timescale 1ns/1ns
module sfe_dev #(
   parameter int BOOT_ARCH = sfe_pkg::ARCH_BOOT_BOTTOM,
   parameter int SMALL_WIPE_CYC = 40000,
   parameter int BLOCK_WIPE_CYC = 100000,
   parameter int ARRAY_WIPE_CYC = 1000000,
   parameter int PROG_CYC = 8000
) (
   input wire logic mclk,
   input wire logic srst,
   sfe_link_if.dev link,
   input wire logic [3:0] protectSizeBits,
   input wire logic protectRegionSide,
   input wire logic [255:0] lockedSectors,
   output logic wipeStart,
   output sfe_pkg::sfe_kind_t wipeKind,
   output logic [23:0] wipeAddr,
   output logic [7:0] progData,
   output logic cycleDone,
   output logic busyFlag,
   output logic writeLatchFlag,
   output logic [7:0] flagStatus,
   output logic [1:0] suspDepth
);
   typedef struct packed {
      logic csPrev;
      logic sclkPrev;
      logic [2:0] bitCnt;
      logic [6:0] shift;
      logic [2:0] byteCnt;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] data;
      sfe_pkg::sfe_cyc_t cyc;
      sfe_pkg::sfe_kind_t kind;
      logic [23:0] curAddr;
      logic [sfe_pkg::TIMER_W-1:0] timer;
      logic [sfe_pkg::LAT_W-1:0] latCnt;
      logic [1:0] depth;
      logic [1:0][2:0] stkKind;
      logic [1:0][23:0] stkAddr;
      logic [1:0][sfe_pkg::TIMER_W-1:0] stkTimer;
      logic write_latch_flag;
      logic suspFlag;
      logic start;
      logic done;
   } sfe_dev_st_t;

   sfe_dev_st_t s_q;
   sfe_dev_st_t s_d;

   logic csS;
   logic sclkS;
   logic sdiS;
   logic [7:0] sect;
   logic [8:0] protCnt;
   logic hwProt;
   logic swLock;
   logic inBoot;
   logic idle;
   logic progOk;
   logic [7:0] byteIn;

   // pins from the far clock pass two flops first
   sfe_sync #(
      .W(3),
      .RST_VAL(3'b100)
   ) u_sync (
      .mclk(mclk),
      .srst(srst),
      .din({link.csN, link.sclk, link.serialIn}),
      .dout({csS, sclkS, sdiS})
   );

   // any address in a block selects it
   assign sect = s_q.addr[sfe_pkg::SECT_LSB +: sfe_pkg::SECT_W];

   // protected span grows from chosen side
   assign protCnt = (protectSizeBits == 4'h0) ? 9'h000 :
      (protectSizeBits > 4'h8) ? sfe_pkg::NUM_SECTORS :
      9'(9'h001 << (protectSizeBits - 4'h1));
   assign hwProt = protectRegionSide ? ({1'b0, sect} < protCnt) :
      ({1'b0, sect} >= (sfe_pkg::NUM_SECTORS - protCnt));
   assign swLock = lockedSectors[sect];

   // boot sectors sit at bottom or top
   assign inBoot = (BOOT_ARCH == sfe_pkg::ARCH_BOOT_BOTTOM) ? (sect < sfe_pkg::BOOT_SECTORS) :
      (BOOT_ARCH == sfe_pkg::ARCH_BOOT_TOP) ?
      ({1'b0, sect} >= (sfe_pkg::NUM_SECTORS - {1'b0, sfe_pkg::BOOT_SECTORS})) : 1'b0;

   assign idle = (s_q.cyc == sfe_pkg::CYC_IDLE);

   // program allowed with nothing suspended, or outside the sector of one suspended block wipe
   assign progOk = (s_q.depth == 2'h0) ||
      ((s_q.depth == 2'h1) && (s_q.stkKind[0] == sfe_pkg::K_BLOCK) &&
      (s_q.stkAddr[0][sfe_pkg::SECT_LSB +: sfe_pkg::SECT_W] != sect));

   assign byteIn = {s_q.shift, sdiS};

   function automatic logic [sfe_pkg::TIMER_W-1:0] cycLen(input sfe_pkg::sfe_kind_t k);
      case (k)
         sfe_pkg::K_SMALL: cycLen = sfe_pkg::TIMER_W'(SMALL_WIPE_CYC - 1);
         sfe_pkg::K_BLOCK: cycLen = sfe_pkg::TIMER_W'(BLOCK_WIPE_CYC - 1);
         sfe_pkg::K_ARRAY: cycLen = sfe_pkg::TIMER_W'(ARRAY_WIPE_CYC - 1);
         default: cycLen = sfe_pkg::TIMER_W'(PROG_CYC - 1);
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.start = 1'b0;
      s_d.done = 1'b0;
      s_d.csPrev = csS;
      s_d.sclkPrev = sclkS;

      case (s_q.cyc)
         sfe_pkg::CYC_RUN: begin
            if (s_q.timer == '0) begin
               s_d.cyc = sfe_pkg::CYC_IDLE;
               s_d.kind = sfe_pkg::K_NONE;
               s_d.done = 1'b1;
            end else begin
               s_d.timer = s_q.timer - 1'b1;
            end
         end
         sfe_pkg::CYC_LAT: begin
            // ready only once latency has elapsed
            if (s_q.latCnt == '0) begin
               s_d.stkKind[s_q.depth[0]] = s_q.kind;
               s_d.stkAddr[s_q.depth[0]] = s_q.curAddr;
               s_d.stkTimer[s_q.depth[0]] = s_q.timer;
               s_d.depth = s_q.depth + 2'h1;
               s_d.cyc = sfe_pkg::CYC_IDLE;
               s_d.kind = sfe_pkg::K_NONE;
            end else begin
               s_d.latCnt = s_q.latCnt - 1'b1;
            end
         end
         default: begin
         end
      endcase

      // chip select fall restarts byte framing
      if (!csS && s_q.csPrev) begin
         s_d.bitCnt = 3'h0;
         s_d.byteCnt = 3'h0;
      end else if (!csS && sclkS && !s_q.sclkPrev) begin
         s_d.shift = byteIn[6:0];
         s_d.bitCnt = s_q.bitCnt + 3'h1;
         if (s_q.bitCnt == 3'h7) begin
            if (s_q.byteCnt != 3'h7) begin
               s_d.byteCnt = s_q.byteCnt + 3'h1;
            end
            if (s_q.byteCnt == 3'h0) begin
               s_d.opcode = byteIn;
            end else if (s_q.byteCnt < sfe_pkg::LEN_WITH_ADDR) begin
               s_d.addr = {s_q.addr[15:0], byteIn};
            end else begin
               s_d.data = byteIn;
            end
         end
      end else if (csS && !s_q.csPrev && (s_q.bitCnt == 3'h0)) begin
         // byte count checked at chip select rise, exact except program's minimum
         case (s_q.opcode)
            sfe_pkg::OP_WRITE_UNLOCK: begin
               if (s_q.byteCnt == sfe_pkg::LEN_OPCODE_ONLY) begin
                  s_d.write_latch_flag = 1'b1;
               end
            end
            sfe_pkg::OP_SMALL_WIPE: begin
               if (s_q.byteCnt == sfe_pkg::LEN_WITH_ADDR && s_q.write_latch_flag && idle &&
                     s_q.depth == 2'h0 && inBoot && !hwProt && !swLock) begin
                  s_d.cyc = sfe_pkg::CYC_RUN;
                  s_d.kind = sfe_pkg::K_SMALL;
                  s_d.curAddr = s_q.addr & sfe_pkg::SUB_MASK;
                  s_d.timer = cycLen(sfe_pkg::K_SMALL);
                  s_d.write_latch_flag = 1'b0;
                  s_d.start = 1'b1;
               end
            end
            sfe_pkg::OP_BLOCK_WIPE: begin
               if (s_q.byteCnt == sfe_pkg::LEN_WITH_ADDR && s_q.write_latch_flag && idle &&
                     s_q.depth == 2'h0 && !hwProt) begin
                  s_d.cyc = sfe_pkg::CYC_RUN;
                  s_d.kind = sfe_pkg::K_BLOCK;
                  s_d.curAddr = s_q.addr & sfe_pkg::SECT_MASK;
                  s_d.timer = cycLen(sfe_pkg::K_BLOCK);
                  s_d.write_latch_flag = 1'b0;
                  s_d.start = 1'b1;
               end
            end
            sfe_pkg::OP_ARRAY_WIPE: begin
               // opcode alone, all size bits clear
               if (s_q.byteCnt == sfe_pkg::LEN_OPCODE_ONLY && s_q.write_latch_flag && idle &&
                     s_q.depth == 2'h0 && protectSizeBits == 4'h0) begin
                  s_d.cyc = sfe_pkg::CYC_RUN;
                  s_d.kind = sfe_pkg::K_ARRAY;
                  s_d.curAddr = 24'h00_0000;
                  s_d.timer = cycLen(sfe_pkg::K_ARRAY);
                  s_d.write_latch_flag = 1'b0;
                  s_d.start = 1'b1;
               end
            end
            sfe_pkg::OP_PROGRAM: begin
               if (s_q.byteCnt >= sfe_pkg::LEN_MIN_PROGRAM && s_q.write_latch_flag && idle &&
                     progOk && !hwProt && !swLock) begin
                  s_d.cyc = sfe_pkg::CYC_RUN;
                  s_d.kind = sfe_pkg::K_PROG;
                  s_d.curAddr = s_q.addr;
                  s_d.timer = cycLen(sfe_pkg::K_PROG);
                  s_d.write_latch_flag = 1'b0;
                  s_d.start = 1'b1;
               end
            end
            sfe_pkg::OP_HALT_MODIFY: begin
               // suspendable kinds, at most two deep
               if (s_q.byteCnt == sfe_pkg::LEN_OPCODE_ONLY && s_q.cyc == sfe_pkg::CYC_RUN &&
                     s_q.timer != '0 && s_q.depth != 2'h2 &&
                     (s_q.kind == sfe_pkg::K_SMALL || s_q.kind == sfe_pkg::K_BLOCK ||
                     s_q.kind == sfe_pkg::K_PROG)) begin
                  // flag set now, latency by kind
                  s_d.cyc = sfe_pkg::CYC_LAT;
                  s_d.suspFlag = 1'b1;
                  s_d.latCnt = (s_q.kind == sfe_pkg::K_PROG) ?
                     sfe_pkg::LAT_W'(sfe_pkg::SUSP_LAT_PROG_CYC - 1) :
                     sfe_pkg::LAT_W'(sfe_pkg::SUSP_LAT_WIPE_CYC - 1);
               end
            end
            sfe_pkg::OP_RESUME: begin
               if (s_q.byteCnt == sfe_pkg::LEN_OPCODE_ONLY && idle && s_q.depth != 2'h0) begin
                  s_d.cyc = sfe_pkg::CYC_RUN;
                  // depth 2 pops entry 1, depth 1 pops entry 0
                  s_d.kind = sfe_pkg::sfe_kind_t'(s_q.stkKind[s_q.depth[1]]);
                  s_d.curAddr = s_q.stkAddr[s_q.depth[1]];
                  s_d.timer = s_q.stkTimer[s_q.depth[1]];
                  s_d.depth = s_q.depth - 2'h1;
                  s_d.suspFlag = (s_q.depth == 2'h2);
               end
            end
            default: begin
            end
         endcase
      end
   end

   // reset stands in for power removal
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q <= '0;
         s_q.csPrev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign wipeStart = s_q.start;
   assign wipeKind = s_q.kind;
   assign wipeAddr = s_q.curAddr;
   assign progData = s_q.data;
   assign cycleDone = s_q.done;
   // busy for the whole running cycle
   assign busyFlag = (s_q.cyc != sfe_pkg::CYC_IDLE);
   assign writeLatchFlag = s_q.write_latch_flag;
   assign suspDepth = s_q.depth;

   always_comb begin
      flagStatus = 8'h00;
      flagStatus[sfe_pkg::FS_READY_BIT] = (s_q.cyc == sfe_pkg::CYC_IDLE);
      flagStatus[sfe_pkg::FS_SUSP_BIT] = s_q.suspFlag;
   end
endmodule

/* sfe_host.sv */
`timescale 1ns/1ns
module sfe_host #(
   parameter int HALF_CYC = sfe_pkg::LINK_HALF_CYC,
   parameter int WIPE_TO_SUSP_CYC = sfe_pkg::WIPE_TO_SUSP_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   sfe_link_if.host link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdOpcode,
   input wire logic [23:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic [2:0] cmdBytes
);
   typedef struct packed {
      sfe_pkg::sfe_hst_t st;
      logic [7:0] div;
      logic [39:0] shift;
      logic [5:0] bitsLeft;
      logic csN;
      logic sclk;
      logic [sfe_pkg::GUARD_W-1:0] guard;
   } sfe_host_st_t;

   sfe_host_st_t s_q;
   sfe_host_st_t s_d;
   logic halfDone;
   logic isWipe;

   assign halfDone = (s_q.div == 8'h00);
   assign isWipe = (cmdOpcode == sfe_pkg::OP_SMALL_WIPE) ||
      (cmdOpcode == sfe_pkg::OP_BLOCK_WIPE) || (cmdOpcode == sfe_pkg::OP_ARRAY_WIPE) ||
      (cmdOpcode == sfe_pkg::OP_RESUME);

   // suspend held back until guard expires
   assign cmdReady = (s_q.st == sfe_pkg::H_IDLE) &&
      !((cmdOpcode == sfe_pkg::OP_HALT_MODIFY) && (s_q.guard != '0));

   always_comb begin
      s_d = s_q;
      if (s_q.guard != '0) begin
         s_d.guard = s_q.guard - 1'b1;
      end
      if (!halfDone) begin
         s_d.div = s_q.div - 8'h01;
      end
      case (s_q.st)
         sfe_pkg::H_IDLE: begin
            if (cmdValid && cmdReady) begin
               // opcode, address, data, most significant first
               s_d.shift = {cmdOpcode, cmdAddr, cmdData};
               s_d.bitsLeft = {cmdBytes, 3'b000};
               s_d.csN = 1'b0;
               s_d.div = 8'(HALF_CYC - 1);
               s_d.st = sfe_pkg::H_LOW;
               if (isWipe) begin
                  s_d.guard = sfe_pkg::GUARD_W'(WIPE_TO_SUSP_CYC);
               end
            end
         end
         sfe_pkg::H_LOW: begin
            if (halfDone) begin
               s_d.sclk = 1'b1;
               s_d.div = 8'(HALF_CYC - 1);
               s_d.st = sfe_pkg::H_HIGH;
            end
         end
         sfe_pkg::H_HIGH: begin
            if (halfDone) begin
               s_d.sclk = 1'b0;
               s_d.div = 8'(HALF_CYC - 1);
               s_d.shift = {s_q.shift[38:0], 1'b0};
               s_d.bitsLeft = s_q.bitsLeft - 6'h01;
               // chip select rises after the last bit
               s_d.st = (s_q.bitsLeft == 6'h01) ? sfe_pkg::H_END : sfe_pkg::H_LOW;
            end
         end
         sfe_pkg::H_END: begin
            if (halfDone) begin
               s_d.csN = 1'b1;
               s_d.div = 8'(HALF_CYC - 1);
               s_d.st = sfe_pkg::H_GAP;
            end
         end
         sfe_pkg::H_GAP: begin
            if (halfDone) begin
               s_d.st = sfe_pkg::H_IDLE;
            end
         end
         default: begin
            s_d.st = sfe_pkg::H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q <= '0;
         s_q.csN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.csN = s_q.csN;
   assign link.sclk = s_q.sclk;
   assign link.serialIn = s_q.shift[39];
endmodule

/* sfe_assertions.sv */
`timescale 1ns/1ns
module sfe_assertions (
   input wire logic mclk,
   input wire logic srst,
   input wire logic csN,
   input wire logic sclk,
   input wire logic wipeStart,
   input wire logic cycleDone,
   input wire logic busyFlag,
   input wire logic writeLatchFlag,
   input wire logic [7:0] flagStatus,
   input wire logic [1:0] suspDepth
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // cycles since the suspend flag rose while still busy; too long for a delay range
   logic [10:0] latSeen_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         latSeen_q <= 11'h000;
      end else if ($rose(flagStatus[2])) begin
         latSeen_q <= 11'h001;
      end else if (latSeen_q != 11'h000 && busyFlag) begin
         latSeen_q <= latSeen_q + 11'h001;
      end else begin
         latSeen_q <= 11'h000;
      end
   end

   a_sclk_rest_low: assert property (csN |-> !sclk)
      else $error("link clock high while deselected");
   // deselect only after the clock has settled low, never mid-bit
   a_cs_after_bit: assert property ($rose(csN) |-> !$past(sclk) && !$past(sclk, 2))
      else $error("chip select rose next to a clock high phase");
   a_start_latch_used: assert property (wipeStart |-> $past(writeLatchFlag) && !writeLatchFlag)
      else $error("cycle started without latch or latch kept");
   a_start_busy_now: assert property (wipeStart |-> busyFlag && !flagStatus[7])
      else $error("cycle start without busy");
   a_start_after_deselect: assert property (wipeStart |-> csN && $past(csN, 2))
      else $error("cycle started while selected");
   a_ready_mirror: assert property (flagStatus == {!busyFlag, 4'h0, flagStatus[2], 2'h0})
      else $error("flag status byte disagrees with busy");
   // program latency is the shorter one, erase the longer
   a_suspend_latency: assert property ((latSeen_q != 11'h000) |->
      (busyFlag ? (latSeen_q <= 11'(sfe_pkg::SUSP_LAT_WIPE_CYC)) :
      (latSeen_q >= 11'(sfe_pkg::SUSP_LAT_PROG_CYC))))
      else $error("suspend latency out of range");
   a_depth_one_step: assert property ($changed(suspDepth) |->
      (suspDepth == $past(suspDepth) + 2'h1) || (suspDepth == $past(suspDepth) - 2'h1))
      else $error("suspend depth jumped");
   a_resume_busy: assert property ((suspDepth < $past(suspDepth)) |->
      busyFlag && !flagStatus[7])
      else $error("resume did not restore busy");
   a_done_idle: assert property (cycleDone |-> ##[0:1] !busyFlag)
      else $error("busy kept after cycle done");

   c_start: cover property (wipeStart);
   c_suspend: cover property ($rose(flagStatus[2]));
   c_nested: cover property (suspDepth == 2'h2);
   c_done: cover property (cycleDone);
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic mclk;
   logic srst;
   logic cmdValid;
   logic cmdReady;
   logic [7:0] cmdOpcode;
   logic [23:0] cmdAddr;
   logic [7:0] cmdData;
   logic [2:0] cmdBytes;
   logic [3:0] protectSizeBits;
   logic protectRegionSide;
   logic [255:0] lockedSectors;
   logic wipeStart;
   sfe_pkg::sfe_kind_t wipeKind;
   logic [23:0] wipeAddr;
   logic [7:0] progData;
   logic cycleDone;
   logic busyFlag;
   logic writeLatchFlag;
   logic [7:0] flagStatus;
   logic [1:0] suspDepth;
   int error_cnt = 0;
   int checked = 0;
   int starts = 0;
   int s0 = 0;
   int dones = 0;

   sfe_link_if link();
   sfe_host #(.WIPE_TO_SUSP_CYC(20)) u_sfe_host (.mclk(mclk), .srst(srst), .link(link.host),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .cmdBytes(cmdBytes));
   // short cycles keep the run small; suspendable ones outlast the suspend frame
   sfe_dev #(.SMALL_WIPE_CYC(3000), .BLOCK_WIPE_CYC(3000), .ARRAY_WIPE_CYC(300),
      .PROG_CYC(3000)) u_sfe_dev (.mclk(mclk), .srst(srst), .link(link.dev),
      .protectSizeBits(protectSizeBits), .protectRegionSide(protectRegionSide),
      .lockedSectors(lockedSectors), .wipeStart(wipeStart), .wipeKind(wipeKind),
      .wipeAddr(wipeAddr), .progData(progData), .cycleDone(cycleDone), .busyFlag(busyFlag),
      .writeLatchFlag(writeLatchFlag), .flagStatus(flagStatus), .suspDepth(suspDepth));
   sfe_assertions u_sfe_assertions (.mclk(mclk), .srst(srst), .csN(link.csN),
      .sclk(link.sclk), .wipeStart(wipeStart), .cycleDone(cycleDone), .busyFlag(busyFlag),
      .writeLatchFlag(writeLatchFlag), .flagStatus(flagStatus), .suspDepth(suspDepth));

   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (wipeStart === 1'h1) begin
         starts <= starts + 1;
      end
      if (cycleDone === 1'h1) begin
         dones <= dones + 1;
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic fail(input string what);
      error_cnt++;
      $display("unexpected %s: expected settle, seen timeout", what);
      report_and_stop();
   endtask

   function automatic void chk(input string what, input logic [23:0] exp,
         input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endfunction

   function automatic void chk1(input string what, input logic exp, input logic got);
      chk(what, {23'h0, exp}, {23'h0, got});
   endfunction

   function automatic void started(input int need);
      chk("starts", 24'(s0 + need), 24'(starts));
      s0 = starts;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic waitReady();
      int n;
      n = 0;
      while (cmdReady !== 1'h1) begin
         if (n++ > 3000) fail("cmdReady");
         tick(1);
      end
   endtask

   // whole frame plus the device's sync delay before anything is looked at
   task automatic send(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] data,
         input logic [2:0] nb);
      cmdOpcode = op;
      cmdAddr = addr;
      cmdData = data;
      cmdBytes = nb;
      waitReady();
      cmdValid = 1'h1;
      tick(1);
      cmdValid = 1'h0;
      tick(2);
      waitReady();
      tick(8);
   endtask

   task automatic wsend(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] data,
         input logic [2:0] nb);
      send(sfe_pkg::OP_WRITE_UNLOCK, 24'h00_0000, 8'h00, 3'h1);
      send(op, addr, data, nb);
   endtask

   task automatic waitIdle();
      int n;
      n = 0;
      while (busyFlag !== 1'h0) begin
         if (n++ > 20000) fail("busyFlag");
         tick(1);
      end
   endtask

   initial begin
      srst = 1'h1;
      cmdValid = 1'h0;
      cmdOpcode = 8'h00;
      cmdAddr = 24'h00_0000;
      cmdData = 8'h00;
      cmdBytes = 3'h1;
      protectSizeBits = 4'h0;
      protectRegionSide = 1'h0;
      lockedSectors = '0;
      tick(12);
      srst = 1'h0;
      tick(1);
      chk("flagStatus", 24'h00_0080, 24'(flagStatus));
      send(sfe_pkg::OP_BLOCK_WIPE, 24'h12_3456, 8'h00, 3'h4);
      started(0);
      send(sfe_pkg::OP_WRITE_UNLOCK, 24'h00_0000, 8'h00, 3'h1);
      chk1("writeLatchFlag", 1'h1, writeLatchFlag);
      send(sfe_pkg::OP_BLOCK_WIPE, 24'h12_3456, 8'h00, 3'h4);
      started(1);
      chk("wipeKind", 24'(sfe_pkg::K_BLOCK), 24'(wipeKind));
      chk("wipeAddr", 24'h12_0000, wipeAddr);
      chk1("busyFlag", 1'h1, busyFlag);
      chk1("writeLatchFlag", 1'h0, writeLatchFlag);
      waitIdle();
      chk1("flagStatus7", 1'h1, flagStatus[7]);
      $display("test sector erase done");
      wsend(sfe_pkg::OP_SMALL_WIPE, 24'h01_2345, 8'h00, 3'h4);
      started(1);
      chk("cycleDone", 24'h00_0001, 24'(dones));
      chk("wipeAddr", 24'h01_2000, wipeAddr);
      wsend(sfe_pkg::OP_SMALL_WIPE, 24'h03_4567, 8'h00, 3'h4);
      started(0);
      chk("wipeAddr", 24'h01_2000, wipeAddr);
      waitIdle();
      wsend(sfe_pkg::OP_SMALL_WIPE, 24'h08_0000, 8'h00, 3'h4);
      started(0);
      $display("test subsector erase done");
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'h12_0000, 8'h00, 3'h3);
      started(0);
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'h12_0000, 8'h00, 3'h5);
      started(0);
      wsend(sfe_pkg::OP_ARRAY_WIPE, 24'h00_0000, 8'h00, 3'h2);
      started(0);
      $display("test frame length done");
      protectSizeBits = 4'h1;
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'hff_1234, 8'h00, 3'h4);
      started(0);
      wsend(sfe_pkg::OP_ARRAY_WIPE, 24'h00_0000, 8'h00, 3'h1);
      started(0);
      protectRegionSide = 1'h1;
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'h00_8000, 8'h00, 3'h4);
      started(0);
      protectSizeBits = 4'h0;
      lockedSectors[3] = 1'h1;
      wsend(sfe_pkg::OP_SMALL_WIPE, 24'h03_1000, 8'h00, 3'h4);
      started(0);
      lockedSectors = '0;
      wsend(sfe_pkg::OP_ARRAY_WIPE, 24'h00_0000, 8'h00, 3'h1);
      started(1);
      chk("wipeKind", 24'(sfe_pkg::K_ARRAY), 24'(wipeKind));
      send(sfe_pkg::OP_HALT_MODIFY, 24'h00_0000, 8'h00, 3'h1);
      chk1("flagStatus2", 1'h0, flagStatus[2]);
      waitIdle();
      chk("suspDepth", 24'h00_0000, 24'(suspDepth));
      $display("test protection done");
      send(sfe_pkg::OP_RESUME, 24'h00_0000, 8'h00, 3'h1);
      chk1("busyFlag", 1'h0, busyFlag);
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'h40_0000, 8'h00, 3'h4);
      started(1);
      send(sfe_pkg::OP_HALT_MODIFY, 24'h00_0000, 8'h00, 3'h1);
      chk1("flagStatus2", 1'h1, flagStatus[2]);
      chk1("busyFlag", 1'h1, busyFlag);
      waitIdle();
      chk("flagStatus", 24'h00_0084, 24'(flagStatus));
      wsend(sfe_pkg::OP_BLOCK_WIPE, 24'h50_0000, 8'h00, 3'h4);
      started(0);
      wsend(sfe_pkg::OP_PROGRAM, 24'h40_0010, 8'h33, 3'h5);
      started(0);
      wsend(sfe_pkg::OP_PROGRAM, 24'h60_0010, 8'h5a, 3'h5);
      started(1);
      chk("progData", 24'h00_005a, 24'(progData));
      send(sfe_pkg::OP_HALT_MODIFY, 24'h00_0000, 8'h00, 3'h1);
      waitIdle();
      chk("suspDepth", 24'h00_0002, 24'(suspDepth));
      wsend(sfe_pkg::OP_PROGRAM, 24'h61_0000, 8'h44, 3'h5);
      started(0);
      send(sfe_pkg::OP_RESUME, 24'h00_0000, 8'h00, 3'h1);
      chk("wipeKind", 24'(sfe_pkg::K_PROG), 24'(wipeKind));
      chk("flagStatus", 24'h00_0004, 24'(flagStatus));
      waitIdle();
      chk("suspDepth", 24'h00_0001, 24'(suspDepth));
      send(sfe_pkg::OP_RESUME, 24'h00_0000, 8'h00, 3'h1);
      chk("wipeKind", 24'(sfe_pkg::K_BLOCK), 24'(wipeKind));
      chk("suspDepth", 24'h00_0000, 24'(suspDepth));
      waitIdle();
      $display("test nested suspend done");
      wsend(sfe_pkg::OP_SMALL_WIPE, 24'h02_0000, 8'h00, 3'h4);
      started(1);
      send(sfe_pkg::OP_HALT_MODIFY, 24'h00_0000, 8'h00, 3'h1);
      waitIdle();
      wsend(sfe_pkg::OP_PROGRAM, 24'h70_0000, 8'h11, 3'h5);
      started(0);
      srst = 1'h1;
      tick(3);
      srst = 1'h0;
      tick(2);
      chk("suspDepth", 24'h00_0000, 24'(suspDepth));
      chk("flagStatus", 24'h00_0080, 24'(flagStatus));
      $display("test subsector suspend done");
      report_and_stop();
   end
endmodule
